//--- include/ssom_defines.vh
/*
 * Constants for the servo status output multiplexer: register offsets,
 * field positions, reset values, control mode codes and enable masks.
 * Assumes it is included by bare name from design and bench files.
 */
// Overview of operation
// - Second in-position judged complete drives output on.
// - Warning output A follows selected warning condition.
// - Warning output B follows its own independent selection.
// - Command-active output high while raw command nonzero.
// - Velocity-limit output high while clamped in velocity mode.
// - Alarm-clearable high only for present clearable alarm.
// - Outputs held off outside their related modes.
// - Network warning flag set by any warning.
// - Network reports command-active as its own flag.
// - No network flags for other three outputs.
`ifndef SSOM_DEFINES_VH
`define SSOM_DEFINES_VH

// Register offsets on the plain register port.
`define SSOM_ADDR_W          4
`define SSOM_REG_SELECT      4'h0
`define SSOM_REG_MODE_EN     4'h1
`define SSOM_REG_STATUS      4'h2
`define SSOM_REG_IRQ_STAT    4'h3
`define SSOM_REG_IRQ_MASK    4'h4

// Widths.
`define SSOM_WARN_W          16
`define SSOM_SEL_W           4
`define SSOM_CMD_W           32
`define SSOM_DATA_W          32
`define SSOM_MODE_W          2
`define SSOM_EV_W            6

// Control mode codes: position, velocity, torque.
`define SSOM_MODE_POS        2'h0
`define SSOM_MODE_VEL        2'h1
`define SSOM_MODE_TRQ        2'h2

// Field positions of the select register.
`define SSOM_SEL_A_LSB       0
`define SSOM_SEL_B_LSB       4

// Per-output mode enable masks, one bit per mode (bit0 pos, bit1 vel, bit2 trq).
`define SSOM_EN_W            3
`define SSOM_EN_IN_POSITION_SECOND_LSB     0
`define SSOM_EN_WARNA_LSB    3
`define SSOM_EN_WARNB_LSB    6
`define SSOM_EN_PCMD_LSB     9
`define SSOM_EN_VLIM_LSB     12
`define SSOM_EN_ALMC_LSB     15
`define SSOM_MODE_EN_W       18
`define SSOM_MODE_EN_RST     18'h3_ffff
`define SSOM_EN_ALL_MODES    3'h7
`define SSOM_EN_VEL_ONLY     3'h2

// Reset values.
`define SSOM_SEL_RST         8'h10
`define SSOM_MASK_RST        6'h00

// Status and event bit positions.
`define SSOM_BIT_IN_POSITION_SECOND        0
`define SSOM_BIT_WARNA       1
`define SSOM_BIT_WARNB       2
`define SSOM_BIT_PCMD        3
`define SSOM_BIT_VLIM        4
`define SSOM_BIT_ALMC        5

`endif

//--- hdl/ssom_status_mux.v
/*
 * Servo status output multiplexer. Builds the discrete connector outputs
 * and the network response flags from internal drive state, with a small
 * register port for selects, mode masks, status and interrupts.
 * Assumes all inputs are synchronous to ref_clk_i and a single clock.
 */
`timescale 1ns/1ps
`default_nettype none
`include "ssom_defines.vh"

module ssom_status_mux (
    // Clock and reset.
    input  wire                      ref_clk_i,
    input  wire                      rst_i,
    // Register port.
    input  wire [`SSOM_ADDR_W-1:0]   reg_addr_i,
    input  wire [`SSOM_DATA_W-1:0]   reg_wdata_i,
    input  wire                      reg_wr_i,
    input  wire                      reg_rd_i,
    output reg  [`SSOM_DATA_W-1:0]   reg_rdata_o,
    // Internal drive state.
    input  wire [`SSOM_MODE_W-1:0]   ctrl_mode_i,
    input  wire                      in_pos_second_done_i,
    input  wire [`SSOM_WARN_W-1:0]   warn_vec_i,
    input  wire [`SSOM_CMD_W-1:0]    pos_cmd_raw_i,
    input  wire                      vel_clamped_i,
    input  wire                      alarm_present_i,
    input  wire                      alarm_clearable_type_i,
    // Connector outputs, one means transistor on.
    output reg                       in_position_second_o,
    output reg                       warning_out_a_o,
    output reg                       warning_out_b_o,
    output reg                       pos_cmd_active_o,
    output reg                       vel_limit_active_o,
    output reg                       alarm_clearable_o,
    // Network response flags.
    output reg                       net_warning_flag_o,
    output reg                       net_in_progress_flag_o,
    // Interrupt.
    output reg                       irq_o
);

    // Warning select fields, A in low nibble, B in high nibble.
    reg  [2*`SSOM_SEL_W-1:0]    sel_q;
    // Per-output mode enable masks.
    reg  [`SSOM_MODE_EN_W-1:0]  mode_en_q;
    // Sticky event bits and their mask.
    reg  [`SSOM_EV_W-1:0]       irq_stat_q;
    reg  [`SSOM_EV_W-1:0]       irq_mask_q;
    // Previous output vector for rising-edge events.
    reg  [`SSOM_EV_W-1:0]       out_prev_q;

    // Next values of the output bits.
    reg  [`SSOM_EV_W-1:0]       out_d;
    reg  [`SSOM_EV_W-1:0]       irq_stat_d;
    wire [`SSOM_EV_W-1:0]       rise_w;
    wire [`SSOM_SEL_W-1:0]      sel_a_w;
    wire [`SSOM_SEL_W-1:0]      sel_b_w;

    assign sel_a_w = sel_q[`SSOM_SEL_A_LSB +: `SSOM_SEL_W];
    assign sel_b_w = sel_q[`SSOM_SEL_B_LSB +: `SSOM_SEL_W];

    // Tests whether the present mode is in a three-bit mode mask.
    function mode_ok;
        input [`SSOM_EN_W-1:0]   mask;
        input [`SSOM_MODE_W-1:0] mode;
        begin
            case (mode)
                `SSOM_MODE_POS: mode_ok = mask[0];
                `SSOM_MODE_VEL: mode_ok = mask[1];
                `SSOM_MODE_TRQ: mode_ok = mask[2];
                default:        mode_ok = 1'b0;
            endcase
        end
    endfunction

    // Picks one warning condition from the warning vector.
    function warn_pick;
        input [`SSOM_WARN_W-1:0] vec;
        input [`SSOM_SEL_W-1:0]  sel;
        begin
            warn_pick = vec[sel];
        end
    endfunction

    // Output conditions, each gated by its mode mask.
    always @* begin
        out_d[`SSOM_BIT_IN_POSITION_SECOND]  = in_pos_second_done_i &&
            mode_ok(mode_en_q[`SSOM_EN_IN_POSITION_SECOND_LSB +: `SSOM_EN_W], ctrl_mode_i);
        out_d[`SSOM_BIT_WARNA] = warn_pick(warn_vec_i, sel_a_w) &&
            mode_ok(mode_en_q[`SSOM_EN_WARNA_LSB +: `SSOM_EN_W], ctrl_mode_i);
        out_d[`SSOM_BIT_WARNB] = warn_pick(warn_vec_i, sel_b_w) &&
            mode_ok(mode_en_q[`SSOM_EN_WARNB_LSB +: `SSOM_EN_W], ctrl_mode_i);
        out_d[`SSOM_BIT_PCMD]  = (pos_cmd_raw_i != {`SSOM_CMD_W{1'b0}}) &&
            mode_ok(mode_en_q[`SSOM_EN_PCMD_LSB +: `SSOM_EN_W], ctrl_mode_i);
        // Velocity clamping only counts under velocity control.
        out_d[`SSOM_BIT_VLIM]  = vel_clamped_i &&
            (ctrl_mode_i == `SSOM_MODE_VEL) &&
            mode_ok(mode_en_q[`SSOM_EN_VLIM_LSB +: `SSOM_EN_W], ctrl_mode_i);
        out_d[`SSOM_BIT_ALMC]  = alarm_present_i && alarm_clearable_type_i &&
            mode_ok(mode_en_q[`SSOM_EN_ALMC_LSB +: `SSOM_EN_W], ctrl_mode_i);
    end

    // An event is a rising edge of any output bit.
    assign rise_w = out_d & ~out_prev_q;

    // Sticky status: write one clears, a new event in the same cycle wins.
    always @* begin
        irq_stat_d = irq_stat_q;
        if (reg_wr_i && (reg_addr_i == `SSOM_REG_IRQ_STAT)) begin
            irq_stat_d = irq_stat_d & ~reg_wdata_i[`SSOM_EV_W-1:0];
        end
        irq_stat_d = irq_stat_d | rise_w;
    end

    // Registered outputs, one bit each, one drives the transistor on.
    always @(posedge ref_clk_i) begin
        if (rst_i) begin
            in_position_second_o   <= 1'b0;
            warning_out_a_o        <= 1'b0;
            warning_out_b_o        <= 1'b0;
            pos_cmd_active_o       <= 1'b0;
            vel_limit_active_o     <= 1'b0;
            alarm_clearable_o      <= 1'b0;
            net_warning_flag_o     <= 1'b0;
            net_in_progress_flag_o <= 1'b0;
            out_prev_q             <= {`SSOM_EV_W{1'b0}};
        end else begin
            in_position_second_o   <= out_d[`SSOM_BIT_IN_POSITION_SECOND];
            warning_out_a_o        <= out_d[`SSOM_BIT_WARNA];
            warning_out_b_o        <= out_d[`SSOM_BIT_WARNB];
            pos_cmd_active_o       <= out_d[`SSOM_BIT_PCMD];
            vel_limit_active_o     <= out_d[`SSOM_BIT_VLIM];
            alarm_clearable_o      <= out_d[`SSOM_BIT_ALMC];
            // Any warning at all raises the network flag, no select or mode.
            net_warning_flag_o     <= |warn_vec_i;
            // Network flag for a nonzero command, not gated by the pin mask.
            net_in_progress_flag_o <= (pos_cmd_raw_i != {`SSOM_CMD_W{1'b0}});
            out_prev_q             <= out_d;
        end
    end

    // Register writes and interrupt state.
    always @(posedge ref_clk_i) begin
        if (rst_i) begin
            sel_q      <= `SSOM_SEL_RST;
            mode_en_q  <= `SSOM_MODE_EN_RST;
            irq_mask_q <= `SSOM_MASK_RST;
            irq_stat_q <= {`SSOM_EV_W{1'b0}};
            irq_o      <= 1'b0;
        end else begin
            irq_stat_q <= irq_stat_d;
            irq_o      <= |(irq_stat_d & irq_mask_q);
            if (reg_wr_i) begin
                case (reg_addr_i)
                    `SSOM_REG_SELECT: begin
                        sel_q <= reg_wdata_i[2*`SSOM_SEL_W-1:0];
                    end
                    `SSOM_REG_MODE_EN: begin
                        mode_en_q <= reg_wdata_i[`SSOM_MODE_EN_W-1:0];
                    end
                    `SSOM_REG_IRQ_MASK: begin
                        irq_mask_q <= reg_wdata_i[`SSOM_EV_W-1:0];
                    end
                    default: begin
                        sel_q <= sel_q;
                    end
                endcase
            end
        end
    end

    // Read data stands one cycle after the read strobe, zero otherwise.
    always @(posedge ref_clk_i) begin
        if (rst_i) begin
            reg_rdata_o <= {`SSOM_DATA_W{1'b0}};
        end else if (reg_rd_i) begin
            case (reg_addr_i)
                `SSOM_REG_SELECT:
                    reg_rdata_o <= {{(`SSOM_DATA_W-2*`SSOM_SEL_W){1'b0}}, sel_q};
                `SSOM_REG_MODE_EN:
                    reg_rdata_o <= {{(`SSOM_DATA_W-`SSOM_MODE_EN_W){1'b0}}, mode_en_q};
                `SSOM_REG_STATUS:
                    reg_rdata_o <= {{(`SSOM_DATA_W-`SSOM_EV_W){1'b0}}, out_prev_q};
                `SSOM_REG_IRQ_STAT:
                    reg_rdata_o <= {{(`SSOM_DATA_W-`SSOM_EV_W){1'b0}}, irq_stat_q};
                `SSOM_REG_IRQ_MASK:
                    reg_rdata_o <= {{(`SSOM_DATA_W-`SSOM_EV_W){1'b0}}, irq_mask_q};
                default:
                    reg_rdata_o <= {`SSOM_DATA_W{1'b0}};
            endcase
        end else begin
            reg_rdata_o <= {`SSOM_DATA_W{1'b0}};
        end
    end

endmodule
`default_nettype wire

//--- tb/ssom_status_mux_props.sv
/* Assertions on the ports of the status output multiplexer.
   Assumes one clock and a synchronous active-high reset. */
`timescale 1ns/1ps
`default_nettype none
`include "ssom_defines.vh"
module ssom_status_mux_props (
    // Clock, reset and drive state.
    input wire logic                    ref_clk_i, rst_i, in_pos_second_done_i,
    input wire logic                    vel_clamped_i, alarm_present_i, alarm_clearable_type_i,
    input wire logic [`SSOM_MODE_W-1:0] ctrl_mode_i,
    input wire logic [`SSOM_WARN_W-1:0] warn_vec_i,
    input wire logic [`SSOM_CMD_W-1:0]  pos_cmd_raw_i,
    // Connector outputs and network flags.
    input wire logic                    in_position_second_o, warning_out_a_o, warning_out_b_o,
    input wire logic                    pos_cmd_active_o, vel_limit_active_o, alarm_clearable_o,
    input wire logic                    net_warning_flag_o, net_in_progress_flag_o
);
    // All six connector outputs as one vector.
    wire logic [5:0] outs = {alarm_clearable_o, vel_limit_active_o, pos_cmd_active_o,
                             warning_out_b_o, warning_out_a_o, in_position_second_o};
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (rst_i);
    // Flags are checked only once the cycle before was out of reset.
    a_pcmd_flag: assert property (!$past(rst_i) |-> net_in_progress_flag_o == ($past(pos_cmd_raw_i) != 0))
        else $error("in-progress flag differs from command");
    a_warn_flag: assert property (!$past(rst_i) |-> net_warning_flag_o == $past(|warn_vec_i))
        else $error("warning flag differs from warnings");
    a_in_position_second_cause: assert property (in_position_second_o |-> $past(in_pos_second_done_i))
        else $error("in-position output without cause");
    a_warna_cause: assert property (warning_out_a_o |-> $past(|warn_vec_i))
        else $error("warning A output without warning");
    a_warnb_cause: assert property (warning_out_b_o |-> $past(|warn_vec_i))
        else $error("warning B output without warning");
    a_pcmd_pin: assert property (pos_cmd_active_o |-> $past(pos_cmd_raw_i) != 0)
        else $error("command output with zero command");
    a_vlim_mode: assert property (vel_limit_active_o |-> $past(ctrl_mode_i == `SSOM_MODE_VEL && vel_clamped_i))
        else $error("velocity limit output without clamp in velocity mode");
    a_almc_cause: assert property (alarm_clearable_o |-> $past(alarm_present_i && alarm_clearable_type_i))
        else $error("clearable output without clearable alarm");
    a_mode_off: assert property ($past(ctrl_mode_i) == 2'h3 |-> outs == 6'h00)
        else $error("output on with no control mode");
    cover property (pos_cmd_active_o);
    cover property (vel_limit_active_o);
    cover property (alarm_clearable_o);
endmodule
bind ssom_status_mux ssom_status_mux_props ssom_status_mux_props_inst (.*);
`default_nettype wire

//--- tb/ssom_host_model.sv
/* Host controller inputs: latch the connector pins and network flags.
   Assumes the same clock as the multiplexer. */
`timescale 1ns/1ps
`default_nettype none
module ssom_host_model (
    // Clock and observed signals.
    input  wire logic       ref_clk_i,
    input  wire logic [5:0] pins_i,
    input  wire logic [1:0] flags_i,
    // Host view.
    output var  logic [7:0] host_view_o
);
    // Pins and flags are kept apart, since their conditions differ.
    always @(posedge ref_clk_i) begin
        host_view_o <= {flags_i, pins_i};
    end
endmodule
`default_nettype wire

//--- tb/tb_ssom_status_mux.sv
/* Random and corner tests of the status output multiplexer.
   Assumes the register map and mode codes of the defines header. */
`timescale 1ns/1ps
`default_nettype none
`include "ssom_defines.vh"
module tb_ssom_status_mux;
    logic ref_clk_i, rst_i, reg_wr_i, reg_rd_i, in_pos_second_done_i, vel_clamped_i;
    logic alarm_present_i, alarm_clearable_type_i, in_position_second_o, warning_out_a_o;
    logic warning_out_b_o, pos_cmd_active_o, vel_limit_active_o, alarm_clearable_o;
    logic net_warning_flag_o, net_in_progress_flag_o, irq_o;
    logic [3:0] reg_addr_i;
    logic [31:0] reg_wdata_i, reg_rdata_o, pos_cmd_raw_i, r;
    logic [1:0] ctrl_mode_i;
    logic [15:0] warn_vec_i;
    logic [7:0] sel, host_view;
    logic [17:0] men;
    integer seed;
    int mismatches, n_tests;
    wire logic [5:0] outs = {alarm_clearable_o, vel_limit_active_o, pos_cmd_active_o,
                             warning_out_b_o, warning_out_a_o, in_position_second_o};
    ssom_status_mux ssom_status_mux_inst (.*);
    ssom_host_model ssom_host_model_inst (.ref_clk_i(ref_clk_i), .pins_i(outs),
        .flags_i({net_warning_flag_o, net_in_progress_flag_o}), .host_view_o(host_view));
    always #5 ref_clk_i = ~ref_clk_i;
    // Expected connector outputs from the present inputs and register shadows.
    function automatic logic [5:0] exp_out(input logic [7:0] s, input logic [17:0] m);
        logic [5:0] c;
        c = {alarm_present_i & alarm_clearable_type_i, vel_clamped_i & (ctrl_mode_i == `SSOM_MODE_VEL),
             pos_cmd_raw_i != 0, warn_vec_i[s[7:4]], warn_vec_i[s[3:0]], in_pos_second_done_i};
        for (int i = 0; i < 6; i++)
            if (ctrl_mode_i == 2'h3 || !m[3*i+ctrl_mode_i]) c[i] = 1'b0;
        return c;
    endfunction
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_tests++;
        if (got !== exp) begin
            mismatches++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge ref_clk_i);
        reg_addr_i <= a;
        reg_wdata_i <= d;
        reg_wr_i <= 1'b1;
        @(posedge ref_clk_i);
        reg_wr_i <= 1'b0;
    endtask
    // Read data stand only in the cycle after the strobe.
    task automatic rd_chk(input logic [3:0] a, input logic [31:0] exp, input string what);
        @(posedge ref_clk_i);
        reg_addr_i <= a;
        reg_rd_i <= 1'b1;
        @(posedge ref_clk_i);
        reg_rd_i <= 1'b0;
        #1 check(what, exp, reg_rdata_o);
        // The read data fall back to zero one cycle later.
        @(posedge ref_clk_i);
        #1 check({what, " gone"}, 32'h0000_0000, reg_rdata_o);
    endtask
    task automatic complete_run;
        $display("Comparisons %0d, mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    initial begin
        #100_000;
        mismatches++;
        complete_run();
    end
    initial begin
        seed = 32'hcec8_0aa2;
        {ref_clk_i, reg_addr_i, reg_wdata_i, reg_wr_i, reg_rd_i, ctrl_mode_i} = '0;
        {in_pos_second_done_i, warn_vec_i, pos_cmd_raw_i, vel_clamped_i} = '0;
        {alarm_present_i, alarm_clearable_type_i} = '0;
        sel = 8'h10;
        men = 18'h3_ffff;
        rst_i = 1'b1;
        repeat (3) @(posedge ref_clk_i);
        rst_i <= 1'b0;
        rd_chk(`SSOM_REG_SELECT, 32'h0000_0010, "select");
        rd_chk(`SSOM_REG_MODE_EN, 32'h0003_ffff, "mode_en");
        rd_chk(`SSOM_REG_IRQ_MASK, 32'h0000_0000, "mask");
        rd_chk(4'hf, 32'h0000_0000, "unmapped");
        // Random drive state under several select and mode mask settings.
        for (int p = 0; p < 4; p++) begin
            if (p > 0) begin
                sel = 8'($random(seed));
                men = (p == 3) ? 18'h3_ffff : 18'($random(seed));
                wr(`SSOM_REG_SELECT, {24'h00_0000, sel});
                wr(`SSOM_REG_MODE_EN, {14'h0000, men});
                rd_chk(`SSOM_REG_SELECT, {24'h00_0000, sel}, "select");
            end
            for (int k = 0; k < 100; k++) begin
                @(posedge ref_clk_i);
                r = $random(seed);
                ctrl_mode_i <= r[1:0];
                in_pos_second_done_i <= r[2];
                vel_clamped_i <= r[3];
                alarm_present_i <= r[4];
                alarm_clearable_type_i <= r[5];
                warn_vec_i <= r[31:16] & 16'($random(seed));
                pos_cmd_raw_i <= r[6] ? r[7] ? 32'h0000_0001 : $random(seed) : 32'h0000_0000;
                @(posedge ref_clk_i);
                #1 check("outputs", exp_out(sel, men), outs);
                // The host model latches one edge later, so wait for it.
                @(posedge ref_clk_i);
                #1 check("flags", {|warn_vec_i, pos_cmd_raw_i != 0}, host_view[7:6]);
                check("host pins", exp_out(sel, men), host_view[5:0]);
            end
        end
        wr(4'h9, 32'hffff_ffff);
        rd_chk(`SSOM_REG_SELECT, {24'h00_0000, sel}, "select after unmapped write");
        // Interrupt: raise, mask and clear with the command output.
        @(posedge ref_clk_i);
        {in_pos_second_done_i, warn_vec_i, pos_cmd_raw_i, vel_clamped_i, alarm_present_i} <= '0;
        ctrl_mode_i <= `SSOM_MODE_POS;
        repeat (2) @(posedge ref_clk_i);
        wr(`SSOM_REG_IRQ_STAT, 32'h0000_003f);
        wr(`SSOM_REG_IRQ_MASK, 32'h0000_0008);
        pos_cmd_raw_i <= 32'h0000_0001;
        repeat (3) @(posedge ref_clk_i);
        #1 check("irq raised", 32'h0000_0001, {31'h0000_0000, irq_o});
        rd_chk(`SSOM_REG_STATUS, 32'h0000_0008, "status");
        rd_chk(`SSOM_REG_IRQ_STAT, 32'h0000_0008, "irq status");
        wr(`SSOM_REG_IRQ_MASK, 32'h0000_0000);
        repeat (2) @(posedge ref_clk_i);
        #1 check("irq masked", 32'h0000_0000, {31'h0000_0000, irq_o});
        wr(`SSOM_REG_IRQ_MASK, 32'h0000_0008);
        wr(`SSOM_REG_IRQ_STAT, 32'h0000_0008);
        repeat (2) @(posedge ref_clk_i);
        #1 check("irq cleared", 32'h0000_0000, {31'h0000_0000, irq_o});
        rd_chk(`SSOM_REG_IRQ_STAT, 32'h0000_0000, "irq status cleared");
        complete_run();
    end
endmodule
`default_nettype wire
